// ---- core/gp_timer_counter.sv ----
`timescale 1ns/100ps
// Functional notes
// - Internal mode counts cycles, wraps after period
// - Idle halts internal counting when idle-stop set
// - Counting resumes once Idle ends
// - Sync mode counts synchronised external rising edges
// - Sync mode obeys idle-stop during Idle
// - Async mode counts external rising edges, wraps
// - Async mode halts in Idle only if idle-stop
// - Interrupt on period match and gate fall
// - Gated mode counts cycles while gate high
// - Prescaler divides by 1, 8, 64, 256
// - Prescaler cleared by count write, timer-off, reset
// - Async external mode keeps counting in Sleep
module gp_timer_counter
    import gp_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // CPU power state
    input wire logic cpuIdle,
    input wire logic cpuSleep,
    // External clock or gate pin
    input wire logic extClockGateInput,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic [15:0] countValue;
        logic [15:0] periodValue;
        logic [15:0] controlWord;
        logic [ST_WIDTH-1:0] status;
        logic [ST_WIDTH-1:0] mask;
        logic [7:0] prescaleCount;
        logic awHeld;
        logic [31:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic irq;
    } timer_s;

    timer_s state;
    timer_s next_state;

    logic extLevel;
    logic extRise;
    logic extFall;

    pin_sync_edge u_pin_sync (
        .clk(clk),
        .srst(srst),
        .pinIn(extClockGateInput),
        .level(extLevel),
        .rise(extRise),
        .fall(extFall)
    );

    function automatic reg_sel_e decodeAddr(input logic [31:0] addr);
        logic [29:0] idx;
        idx = addr[31:2];
        if (addr[1:0] != 2'h0) begin
            decodeAddr = SEL_NONE;
        end else if (idx == {18'h0, IDX_COUNT}) begin
            decodeAddr = SEL_COUNT;
        end else if (idx == {18'h0, IDX_PERIOD}) begin
            decodeAddr = SEL_PERIOD;
        end else if (idx == {18'h0, IDX_CONTROL}) begin
            decodeAddr = SEL_CONTROL;
        end else if (idx == {18'h0, IDX_STATUS}) begin
            decodeAddr = SEL_STATUS;
        end else if (idx == {18'h0, IDX_MASK}) begin
            decodeAddr = SEL_MASK;
        end else begin
            decodeAddr = SEL_NONE;
        end
    endfunction

    function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        mergeLanes = old;
        if (strb[0]) begin
            mergeLanes[7:0] = data[7:0];
        end
        if (strb[1]) begin
            mergeLanes[15:8] = data[15:8];
        end
    endfunction

    logic timerOn;
    logic idleStop;
    logic gateEnable;
    logic syncSelect;
    logic clockSource;
    logic [1:0] prescaleSelect;
    logic [7:0] prescaleLimit;
    logic asyncExternal;
    logic running;
    logic sourcePulse;
    logic countTick;
    logic periodMatch;
    logic gateFallEvent;
    logic doWrite;
    reg_sel_e writeSel;
    reg_sel_e readSel;
    logic [15:0] writeValue;
    logic [ST_WIDTH-1:0] clearBits;
    logic [15:0] readValue;

    always_comb begin
        next_state = state;
        timerOn = state.controlWord[CTL_TIMER_ON];
        idleStop = state.controlWord[CTL_IDLE_STOP];
        gateEnable = state.controlWord[CTL_GATE_ENABLE];
        syncSelect = state.controlWord[CTL_SYNC_SELECT];
        clockSource = state.controlWord[CTL_CLOCK_SOURCE];
        prescaleSelect = state.controlWord[CTL_PRESCALE_HI:CTL_PRESCALE_LO];
        asyncExternal = clockSource && !syncSelect;

        case (prescaleSelect)
            2'h0: prescaleLimit = PRE_DIV1;
            2'h1: prescaleLimit = PRE_DIV8;
            2'h2: prescaleLimit = PRE_DIV64;
            default: prescaleLimit = PRE_DIV256;
        endcase

        // Idle stalls only with idle-stop set; release of Idle resumes
        // Sleep stops core clocks, except for the async external source
        running = timerOn && !(cpuIdle && idleStop) && !(cpuSleep && !asyncExternal);

        if (clockSource) begin
            sourcePulse = extRise;
        end else if (gateEnable) begin
            sourcePulse = extLevel;
        end else begin
            sourcePulse = 1'b1;
        end

        countTick = 1'b0;
        if (!timerOn) begin
            next_state.prescaleCount = 8'h00;
        end else if (running && sourcePulse) begin
            if (state.prescaleCount >= prescaleLimit) begin
                next_state.prescaleCount = 8'h00;
                countTick = 1'b1;
            end else begin
                next_state.prescaleCount = state.prescaleCount + 8'h01;
            end
        end

        periodMatch = 1'b0;
        if (countTick) begin
            if (state.countValue == state.periodValue) begin
                next_state.countValue = 16'h0000;
                periodMatch = 1'b1;
            end else begin
                next_state.countValue = state.countValue + 16'h0001;
            end
        end

        gateFallEvent = timerOn && gateEnable && !clockSource && extFall;

        // Write channel: each half is held until both have arrived
        if (awvalid && state.awReady) begin
            next_state.awHeld = 1'b1;
            next_state.awAddr = awaddr;
            next_state.awReady = 1'b0;
        end
        if (wvalid && state.wReady) begin
            next_state.wHeld = 1'b1;
            next_state.wData = wdata;
            next_state.wStrb = wstrb;
            next_state.wReady = 1'b0;
        end
        doWrite = state.awHeld && state.wHeld && !state.bValid;
        writeSel = decodeAddr(state.awAddr);
        writeValue = 16'h0000;
        clearBits = '0;
        if (doWrite) begin
            next_state.awHeld = 1'b0;
            next_state.wHeld = 1'b0;
            next_state.bValid = 1'b1;
            next_state.bResp = (writeSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (writeSel == SEL_COUNT) begin
                writeValue = mergeLanes(state.countValue, state.wData, state.wStrb);
                next_state.countValue = writeValue;
                next_state.prescaleCount = 8'h00;
            end else if (writeSel == SEL_PERIOD) begin
                writeValue = mergeLanes(state.periodValue, state.wData, state.wStrb);
                next_state.periodValue = writeValue;
            end else if (writeSel == SEL_CONTROL) begin
                // Control writes leave the count and prescaler alone
                writeValue = mergeLanes(state.controlWord, state.wData, state.wStrb);
                next_state.controlWord = writeValue & CTL_WRITE_MASK;
            end else if (writeSel == SEL_STATUS) begin
                clearBits = state.wStrb[0] ? state.wData[ST_WIDTH-1:0] : '0;
            end else if (writeSel == SEL_MASK) begin
                if (state.wStrb[0]) begin
                    next_state.mask = state.wData[ST_WIDTH-1:0];
                end
            end
        end
        if (state.bValid && bready) begin
            next_state.bValid = 1'b0;
            next_state.awReady = 1'b1;
            next_state.wReady = 1'b1;
        end

        // Sticky events win over a simultaneous write-one clear
        next_state.status = (state.status & ~clearBits)
            | {gateFallEvent, periodMatch};
        next_state.irq = |(next_state.status & next_state.mask);

        // Read channel
        readSel = decodeAddr(araddr);
        if (readSel == SEL_COUNT) begin
            readValue = state.countValue;
        end else if (readSel == SEL_PERIOD) begin
            readValue = state.periodValue;
        end else if (readSel == SEL_CONTROL) begin
            readValue = state.controlWord;
        end else if (readSel == SEL_STATUS) begin
            readValue = {14'h0, state.status};
        end else if (readSel == SEL_MASK) begin
            readValue = {14'h0, state.mask};
        end else begin
            readValue = 16'h0000;
        end
        if (arvalid && state.arReady) begin
            next_state.arReady = 1'b0;
            next_state.rValid = 1'b1;
            next_state.rData = {16'h0, readValue};
            next_state.rResp = (readSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (state.rValid && rready) begin
            next_state.rValid = 1'b0;
            next_state.arReady = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
            state.countValue <= RST_COUNT;
            state.periodValue <= RST_PERIOD;
            state.controlWord <= RST_CONTROL;
            state.status <= RST_STATUS;
            state.mask <= RST_MASK;
            state.awReady <= 1'b1;
            state.wReady <= 1'b1;
            state.arReady <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign awready = state.awReady;
    assign wready = state.wReady;
    assign bvalid = state.bValid;
    assign bresp = state.bResp;
    assign arready = state.arReady;
    assign rvalid = state.rValid;
    assign rdata = state.rData;
    assign rresp = state.rResp;
    assign irq = state.irq;

endmodule

// ---- pkg/gp_timer_pkg.sv ----
package gp_timer_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_COUNT = 12'h100;
    localparam logic [11:0] IDX_PERIOD = 12'h102;
    localparam logic [11:0] IDX_CONTROL = 12'h104;
    localparam logic [11:0] IDX_STATUS = 12'h108;
    localparam logic [11:0] IDX_MASK = 12'h109;

    // Control word field positions
    localparam int CTL_TIMER_ON = 15;
    localparam int CTL_IDLE_STOP = 13;
    localparam int CTL_GATE_ENABLE = 6;
    localparam int CTL_PRESCALE_HI = 5;
    localparam int CTL_PRESCALE_LO = 4;
    localparam int CTL_SYNC_SELECT = 2;
    localparam int CTL_CLOCK_SOURCE = 1;
    localparam logic [15:0] CTL_WRITE_MASK = 16'ha076;

    // Status and mask bit positions
    localparam int ST_MATCH = 0;
    localparam int ST_GATE_FALL = 1;
    localparam int ST_WIDTH = 2;

    // Values after reset
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [ST_WIDTH-1:0] RST_STATUS = 2'h0;
    localparam logic [ST_WIDTH-1:0] RST_MASK = 2'h0;

    // Prescale terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PRE_DIV1 = 8'h00;
    localparam logic [7:0] PRE_DIV8 = 8'h07;
    localparam logic [7:0] PRE_DIV64 = 8'h3f;
    localparam logic [7:0] PRE_DIV256 = 8'hff;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_COUNT,
        SEL_PERIOD,
        SEL_CONTROL,
        SEL_STATUS,
        SEL_MASK
    } reg_sel_e;

endpackage

// ---- core/pin_sync_edge.sv ----
`timescale 1ns/100ps
module pin_sync_edge
    import gp_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pin
    input wire logic pinIn,
    // Synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
        logic rise;
        logic fall;
    } sync_s;

    sync_s state;
    sync_s next_state;

    always_comb begin
        next_state = state;
        // First stage is read only by the second stage
        next_state.meta = pinIn;
        next_state.stable = state.meta;
        next_state.prev = state.stable;
        next_state.rise = state.stable && !state.prev;
        next_state.fall = !state.stable && state.prev;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.prev;
    assign rise = state.rise;
    assign fall = state.fall;

endmodule

// ---- test/ext_pin_source.sv ----
`timescale 1ns/100ps
module ext_pin_source (
    // Clock
    input wire logic clk,
    // 0 low, 1 high, 2 pulse train
    input wire logic [1:0] pinMode,
    // Pin
    output logic pin
);
    logic [1:0] phase = 2'h0;
    logic level = 1'b0;

    // Pulses four cycles wide, eight-cycle period
    always @(posedge clk) begin
        phase <= phase + 2'h1;
        if (phase == 2'h3) begin
            level <= ~level;
        end
    end

    assign pin = (pinMode == 2'h2) ? level : pinMode[0];
endmodule

// ---- test/gp_timer_counter_sva.sv ----
`timescale 1ns/100ps
module gp_timer_counter_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped");
    a_ar_busy: assert property (arvalid && arready |=> !arready)
        else $error("second read taken");
    a_aw_busy: assert property (bvalid |-> !awready)
        else $error("write taken before response");
    a_rdata_width: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_err_data: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
        else $error("refused read carries data");
    a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) srst |=> !bvalid && !rvalid && !irq)
        else $error("outputs active after reset");
endmodule

bind gp_timer_counter gp_timer_counter_sva i_gp_timer_counter_sva (.clk, .srst, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .irq);

// ---- test/gp_timer_counter_tb_top.sv ----
`timescale 1ns/100ps
module gp_timer_counter_tb_top
    import gp_timer_pkg::*;
;
    localparam logic [31:0] ON = 32'h8000, IDL = 32'h2000, GT = 32'h0040, SYN = 32'h0004, CS = 32'h0002;
    localparam logic [31:0] A_CNT = 32'h400, A_PER = 32'h408, A_CTL = 32'h410, A_ST = 32'h420, A_MSK = 32'h424;
    logic clk = 0, srst = 1, cpuIdle = 0, cpuSleep = 0, pin, irq;
    // Slow master: response ready held low a few cycles after valid
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, slow = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, v;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, resp, pinMode = 2'h0;
    int num_errors = 0, samples_checked = 0, cyc = 0, tw, t0, dn;
    int shifts[4] = '{0, 3, 6, 8};

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    gp_timer_counter i_gp_timer_counter (.clk(clk), .srst(srst), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
        .extClockGateInput(pin), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .irq(irq));
    ext_pin_source i_ext_pin_source (.clk(clk), .pinMode(pinMode), .pin(pin));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        awvalid <= 1;
        awaddr <= a;
        wvalid <= 1;
        wdata <= d;
        bready <= !slow;
        fork
            begin do @(posedge clk); while (!awready); awvalid <= 0; end
            begin do @(posedge clk); while (!wready); wvalid <= 0; end
        join
        if (slow) begin
            do @(posedge clk); while (!bvalid);
            repeat (2) @(posedge clk);
            bready <= 1;
        end
        do @(posedge clk); while (!bvalid);
        bready <= 0;
        resp = bresp;
        tw = cyc;
    endtask

    task rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        arvalid <= 1;
        araddr <= a;
        rready <= !slow;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        if (slow) begin
            do @(posedge clk); while (!rvalid);
            repeat (2) @(posedge clk);
            rready <= 1;
        end
        do @(posedge clk); while (!rvalid);
        rready <= 0;
        d = rdata;
        resp = rresp;
    endtask

    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        rd(a, v);
        chk(v, exp);
    endtask

    // Runs the timer for a while from zero; dn holds the cycles it was on
    task measure(input logic [31:0] ctl, input int n);
        wr(A_CNT, 0);
        wr(A_CTL, ctl);
        t0 = tw;
        repeat (n) @(posedge clk);
        wr(A_CTL, 0);
        dn = tw - t0;
        rd(A_CNT, v);
    endtask

    task report_and_stop;
        $display("Errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 0;
        rdchk(A_CNT, RST_COUNT);
        rdchk(A_PER, RST_PERIOD);
        rdchk(A_CTL, RST_CONTROL);
        rdchk(A_ST, RST_STATUS);
        rdchk(A_MSK, RST_MASK);
        rdchk(32'h4fc, 0);
        chk(resp, RESP_SLVERR);
        wr(32'h4fc, 1);
        chk(resp, RESP_SLVERR);
        wr(A_CTL, 32'hffff);
        rdchk(A_CTL, 32'ha076);
        slow = 1;
        wr(A_CNT, 32'h1234);
        chk(resp, RESP_OKAY);
        wr(A_CTL, 0);
        rdchk(A_CNT, 32'h1234);
        chk(resp, RESP_OKAY);
        slow = 0;
        for (int i = 0; i < 4; i++) begin
            measure(ON | (i << 4), 600);
            chk(v, dn >> shifts[i]);
        end
        wr(A_PER, 9);
        wr(A_MSK, 1);
        measure(ON, 40);
        chk(v, dn % 10);
        rdchk(A_ST, 1);
        chk(irq, 1);
        wr(A_ST, 1);
        rdchk(A_ST, 0);
        chk(irq, 0);
        wr(A_PER, 32'hffff);
        cpuIdle <= 1;
        measure(ON | IDL, 50);
        chk(v, 0);
        measure(ON, 50);
        chk(v, dn);
        cpuIdle <= 0;
        measure(ON | IDL, 50);
        chk(v, dn);
        pinMode <= 2;
        measure(ON | CS | SYN, 200);
        chk(v + 1 >= dn / 8 && v <= dn / 8 + 1, 1);
        cpuIdle <= 1;
        measure(ON | CS | SYN | IDL, 200);
        chk(v, 0);
        measure(ON | CS | SYN, 200);
        chk(v + 1 >= dn / 8 && v <= dn / 8 + 1, 1);
        measure(ON | CS, 200);
        chk(v + 1 >= dn / 8 && v <= dn / 8 + 1, 1);
        measure(ON | CS | IDL, 200);
        chk(v, 0);
        cpuIdle <= 0;
        cpuSleep <= 1;
        measure(ON | CS, 200);
        chk(v + 1 >= dn / 8 && v <= dn / 8 + 1, 1);
        measure(ON | CS | SYN, 200);
        chk(v, 0);
        cpuSleep <= 0;
        pinMode <= 1;
        measure(ON | GT, 60);
        chk(v, dn);
        pinMode <= 0;
        measure(ON | GT, 60);
        chk(v, 0);
        wr(A_MSK, 2);
        wr(A_CTL, ON | GT);
        pinMode <= 1;
        repeat (10) @(posedge clk);
        pinMode <= 0;
        repeat (10) @(posedge clk);
        rdchk(A_ST, 2);
        chk(irq, 1);
        wr(A_ST, 2);
        wr(A_CTL, 0);
        rdchk(A_ST, 0);
        report_and_stop();
    end
endmodule
